// File: logic/sdh_pointer_generator.sv
// Pointer generation state machine with its output FIFO.
`timescale 1ns/1ps
`default_nettype none

module sdh_pointer_generator
  import ptr_gen_pkg::*;
#(
  parameter int FILL_W = 8,
  parameter int DEPTH = FIFO_DEPTH,
  parameter logic [9:0] OFS_MAX_AU4 = 10'h3ff,
  parameter logic [9:0] OFS_MAX_TU3 = 10'h3ff,
  parameter logic [9:0] OFS_MAX_TU2 = 10'h3ff,
  parameter logic [9:0] OFS_MAX_TU12 = 10'h3ff
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Frame timing and structure
  input wire logic frame_slot,
  input wire ptr_type_t ptr_type,
  input wire logic server_signal_fail,
  // Elastic store
  input wire logic [FILL_W-1:0] fill_level,
  input wire logic [FILL_W-1:0] thr_low,
  input wire logic [FILL_W-1:0] thr_high,
  input wire logic es_overflow,
  input wire logic es_underflow,
  // Write-side pointer interpreter
  input wire logic pi_controls,
  input wire logic rx_point,
  input wire logic rx_ndf_enable,
  input wire logic rx_new_point,
  input wire logic [9:0] rx_offset,
  // Pointer stream to the frame multiplexer
  output logic ptr_valid,
  input wire logic ptr_ready,
  output ptr_word_t ptr_word,
  // Status
  output logic [9:0] active_offset,
  output gen_state_t gen_state,
  output logic fill_low,
  output logic fill_high,
  output logic offset_jump,
  output logic offset_steady,
  output logic slot_overrun
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  gen_state_t state_r;
  gen_state_t state_nxt;
  logic [9:0] active_r;
  logic [9:0] active_nxt;
  logic [9:0] new_ofs_r;
  logic [9:0] np_ofs_r;
  logic [1:0] np_cnt_r;
  logic [1:0] np_cnt_nxt;
  logic jump_r;
  logic jump_nxt;
  logic steady_r;
  logic pend_r;
  logic low_r;
  logic high_r;
  logic overrun_r;
  ptr_word_t wr_word;
  wire logic fifo_ready;
  wire ptr_word_t fifo_data;
  wire logic fifo_valid;

  // ----------------------------------------------------------------
  // Event decode
  // ----------------------------------------------------------------

  // Occupancy compare against the two thresholds.
  wire logic low_now = (fill_level < thr_low);
  wire logic high_now = (fill_level > thr_high);

  // Run of equal new pointers from the interpreter.
  wire logic np_same = (np_cnt_r != 2'h0) && (rx_offset == np_ofs_r);
  wire logic np_hit = rx_point && rx_new_point && np_same && (np_cnt_r == 2'h2);
  wire logic ndf_hit = rx_point && rx_ndf_enable;
  wire logic jump_set = pi_controls &&
                        (ndf_hit || np_hit || es_overflow || es_underflow);

  // Slot taken when the FIFO can accept the word.
  wire logic take = pend_r && fifo_ready;
  wire logic in_norm = (state_r == ST_NORM);
  wire logic act_ndf = take && in_norm && jump_r;
  wire logic act_inc = take && in_norm && !jump_r && low_now;
  wire logic act_dec = take && in_norm && !jump_r && !low_now && high_now;
  wire logic jump_clr = act_ndf;

  // Offset limits per structure.
  wire logic [9:0] ofs_max = (ptr_type == TYP_AU4) ? OFS_MAX_AU4 :
                             (ptr_type == TYP_TU3) ? OFS_MAX_TU3 :
                             (ptr_type == TYP_TU2) ? OFS_MAX_TU2 : OFS_MAX_TU12;
  wire logic [9:0] ofs_up = (active_r >= ofs_max) ? OFS_RESET : active_r + OFS_ONE;
  wire logic [9:0] ofs_dn = (active_r == OFS_RESET) ? ofs_max : active_r - OFS_ONE;
  wire logic [1:0] ss_code = (ptr_type == TYP_TU2) ? SS_TU2 : SS_MAIN;
  wire logic [1:0] just_n = (ptr_type == TYP_AU4) ? JUST_BYTES_AU4 : JUST_BYTES_ONE;

  // Event latch: a new event in the cycle of its clear is kept.
  assign jump_nxt = jump_set | (jump_r & ~jump_clr);

  // New-pointer run counter; a different offset restarts the run.
  always_comb
  begin
    np_cnt_nxt = np_cnt_r;
    if (rx_point)
    begin
      if (!rx_new_point || np_hit)
        np_cnt_nxt = 2'h0;
      else if (np_same)
        np_cnt_nxt = np_cnt_r + NEWPT_ONE;
      else
        np_cnt_nxt = NEWPT_ONE;
    end
  end

  // ----------------------------------------------------------------
  // Next state, offset and outgoing word
  // ----------------------------------------------------------------

  // Special states last exactly one frame slot.
  always_comb
  begin
    state_nxt = state_r;
    if (take)
    begin
      case (state_r)
        ST_NORM:
        begin
          if (act_ndf)
            state_nxt = ST_NDF;
          else if (act_inc)
            state_nxt = ST_INC;
          else if (act_dec)
            state_nxt = ST_DEC;
          else
            state_nxt = ST_NORM;
        end
        ST_NDF, ST_INC, ST_DEC:
          state_nxt = ST_NORM;
        default:
          state_nxt = ST_NORM;
      endcase
    end
  end

  // Active offset moves only with an action.
  always_comb
  begin
    active_nxt = active_r;
    if (act_ndf)
      active_nxt = new_ofs_r;
    else if (act_inc)
      active_nxt = ofs_up;
    else if (act_dec)
      active_nxt = ofs_dn;
  end

  // Pointer assembly from the old offset and the chosen action.
  always_comb
  begin
    wr_word = '0;
    wr_word.ssf = server_signal_fail;
    wr_word.ss = ss_code;
    wr_word.ndf = NDF_OFF;
    wr_word.value = active_r;
    wr_word.just = JUST_NONE;
    wr_word.nbytes = 2'h0;
    if (act_ndf)
    begin
      wr_word.ndf = NDF_ON;
      wr_word.value = new_ofs_r;
    end
    else if (act_inc)
    begin
      wr_word.value = active_r ^ I_MASK;
      wr_word.just = JUST_POS;
      wr_word.nbytes = just_n;
    end
    else if (act_dec)
    begin
      wr_word.value = active_r ^ D_MASK;
      wr_word.just = JUST_NEG;
      wr_word.nbytes = just_n;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------

  // Machine and offset.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_r <= ST_NORM;
      active_r <= OFS_RESET;
    end
    else
    begin
      state_r <= state_nxt;
      active_r <= active_nxt;
    end
  end

  // Events and the candidate offset for new data.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      jump_r <= 1'b0;
      steady_r <= 1'b1;
      np_cnt_r <= 2'h0;
      np_ofs_r <= OFS_RESET;
      new_ofs_r <= OFS_RESET;
    end
    else
    begin
      jump_r <= jump_nxt;
      steady_r <= ~jump_nxt;
      np_cnt_r <= np_cnt_nxt;
      if (rx_point && rx_new_point && !np_same)
        np_ofs_r <= rx_offset;
      if (pi_controls && (ndf_hit || np_hit))
        new_ofs_r <= rx_offset;
    end
  end

  // Slot pending while the FIFO is full; a second slot then overruns.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pend_r <= 1'b0;
      overrun_r <= 1'b0;
      low_r <= 1'b0;
      high_r <= 1'b0;
    end
    else
    begin
      pend_r <= frame_slot | (pend_r & ~take);
      overrun_r <= frame_slot & pend_r & ~take;
      low_r <= low_now;
      high_r <= high_now;
    end
  end

  // ----------------------------------------------------------------
  // Output FIFO and status
  // ----------------------------------------------------------------
  ptr_fifo #(
    .WIDTH(WORD_W),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clk(clk),
    .resetn(resetn),
    .in_valid(take),
    .in_ready(fifo_ready),
    .in_data(wr_word),
    .out_valid(fifo_valid),
    .out_ready(ptr_ready),
    .out_data(fifo_data)
  );

  // Status taken straight from registers.
  assign ptr_valid = fifo_valid;
  assign ptr_word = fifo_data;
  assign active_offset = active_r;
  assign gen_state = state_r;
  assign fill_low = low_r;
  assign fill_high = high_r;
  assign offset_jump = jump_r;
  assign offset_steady = steady_r;
  assign slot_overrun = overrun_r;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_state_onehot: assert property (@(posedge clk) disable iff (!resetn)
    $onehot(state_r))
    else $error("State register is not one of four codes.");

  a_leave_norm_cause: assert property (@(posedge clk) disable iff (!resetn)
    (state_r == ST_NORM) ##1 (state_r != ST_NORM) |->
      $past(take) && ($past(jump_r) || $past(low_now) || $past(high_now)))
    else $error("Normal state left without an event.");

  a_special_returns: assert property (@(posedge clk) disable iff (!resetn)
    (state_r != ST_NORM) && take |=> (state_r == ST_NORM))
    else $error("Special state did not return to normal.");

  a_special_holds: assert property (@(posedge clk) disable iff (!resetn)
    (state_r != ST_NORM) && !take |=> $stable(state_r) && $stable(active_r))
    else $error("Special state changed between frame slots.");

  a_fill_flags: assert property (@(posedge clk) disable iff (!resetn)
    ##1 (low_r == $past(fill_level < thr_low)) && (high_r == $past(fill_level > thr_high)))
    else $error("Fill flags do not follow the thresholds.");

  a_jump_set: assert property (@(posedge clk) disable iff (!resetn)
    pi_controls && (es_overflow || es_underflow || ndf_hit) |=> jump_r && !steady_r)
    else $error("Offset jump not raised.");

  a_no_jump_alone: assert property (@(posedge clk) disable iff (!resetn)
    !jump_r && !pi_controls |=> !jump_r)
    else $error("Offset jump raised without interpreter control.");

  a_ssf_passed: assert property (@(posedge clk) disable iff (!resetn)
    take |-> (wr_word.ssf == server_signal_fail))
    else $error("Signal fail mark not carried to the mux.");

  a_inc_action: assert property (@(posedge clk) disable iff (!resetn)
    act_inc |-> (wr_word.value == (active_r ^ I_MASK)) && (wr_word.just == JUST_POS)
      ##1 (active_r == $past(ofs_up)) && (state_r == ST_INC))
    else $error("Increment pointer or offset wrong.");

  a_dec_action: assert property (@(posedge clk) disable iff (!resetn)
    act_dec |-> (wr_word.value == (active_r ^ D_MASK)) && (wr_word.just == JUST_NEG)
      ##1 (active_r == $past(ofs_dn)) && (state_r == ST_DEC))
    else $error("Decrement pointer or offset wrong.");

  a_ndf_action: assert property (@(posedge clk) disable iff (!resetn)
    act_ndf |-> (wr_word.ndf == NDF_ON) && (wr_word.value == new_ofs_r) ##1
      (active_r == $past(new_ofs_r)) && (!jump_r || $past(jump_set)))
    else $error("New data pointer or offset wrong.");

  a_norm_pointer: assert property (@(posedge clk) disable iff (!resetn)
    take && !act_ndf && !act_inc && !act_dec |->
      (wr_word.ndf == NDF_OFF) && (wr_word.value == active_r) ##1 $stable(active_r))
    else $error("Normal pointer does not carry the active offset.");

  a_size_bits: assert property (@(posedge clk) disable iff (!resetn)
    take |-> (wr_word.ss == ((ptr_type == TYP_TU2) ? 2'h0 : 2'h2)))
    else $error("Size bits wrong for the structure.");

  a_ndf_codes: assert property (@(posedge clk) disable iff (!resetn)
    take |-> (wr_word.ndf == 4'h9) || (wr_word.ndf == 4'h6))
    else $error("NDF code is neither enabled nor disabled.");

  a_jump_first: assert property (@(posedge clk) disable iff (!resetn)
    take && in_norm && jump_r && low_now |=> (state_r == ST_NDF))
    else $error("Offset jump lost its priority.");

endmodule : sdh_pointer_generator
`default_nettype wire

// File: logic/ptr_gen_pkg.sv
// Shared constants, codes and word layout of the pointer generator.
package ptr_gen_pkg;

  // ----------------------------------------------------------------
  // Pointer field codes
  // ----------------------------------------------------------------
  localparam int OFS_W = 10;
  localparam logic [3:0] NDF_ON = 4'h9;
  localparam logic [3:0] NDF_OFF = 4'h6;
  localparam logic [1:0] SS_MAIN = 2'h2;
  localparam logic [1:0] SS_TU2 = 2'h0;
  localparam logic [9:0] I_MASK = 10'h2aa;
  localparam logic [9:0] D_MASK = 10'h155;
  localparam logic [9:0] OFS_RESET = 10'h000;
  localparam logic [9:0] OFS_ONE = 10'h001;

  // ----------------------------------------------------------------
  // Counts
  // ----------------------------------------------------------------
  localparam logic [1:0] NEWPT_RUN = 2'h3;
  localparam logic [1:0] NEWPT_ONE = 2'h1;
  localparam logic [1:0] JUST_BYTES_ONE = 2'h1;
  localparam logic [1:0] JUST_BYTES_AU4 = 2'h3;
  localparam int FIFO_DEPTH = 16;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    TYP_AU4 = 2'h0,
    TYP_TU3 = 2'h1,
    TYP_TU2 = 2'h2,
    TYP_TU12 = 2'h3
  } ptr_type_t;

  typedef enum logic [3:0] {
    ST_NORM = 4'h1,
    ST_NDF = 4'h2,
    ST_INC = 4'h4,
    ST_DEC = 4'h8
  } gen_state_t;

  typedef enum logic [1:0] {
    JUST_NONE = 2'h0,
    JUST_POS = 2'h1,
    JUST_NEG = 2'h2
  } just_t;

  // One generated pointer with its justification order for the mux.
  typedef struct packed {
    logic ssf;
    just_t just;
    logic [1:0] nbytes;
    logic [3:0] ndf;
    logic [1:0] ss;
    logic [9:0] value;
  } ptr_word_t;

  localparam int WORD_W = $bits(ptr_word_t);

endpackage : ptr_gen_pkg

// File: logic/ptr_fifo.sv
// Parameterised FIFO with a registered output stage.
`timescale 1ns/1ps
`default_nettype none

module ptr_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
  localparam logic [AW:0] CNT_ONE = (AW+1)'(1);
  localparam logic [AW-1:0] PTR_ONE = AW'(1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0] count_r;
  logic [WIDTH-1:0] out_data_r;
  logic out_valid_r;
  wire logic push;
  wire logic pop;

  // Handshake decode; the output register refills when empty or drained.
  assign in_ready = (count_r != FULL_CNT);
  assign push = in_valid & in_ready;
  assign pop = (count_r != '0) & (~out_valid_r | out_ready);
  assign out_valid = out_valid_r;
  assign out_data = out_data_r;

  // Storage array, no reset needed.
  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem[wr_ptr_r] <= in_data;
    end
  end

  // Pointers and occupancy.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end
    else
    begin
      if (push)
        wr_ptr_r <= wr_ptr_r + PTR_ONE;
      if (pop)
        rd_ptr_r <= rd_ptr_r + PTR_ONE;
      if (push && !pop)
        count_r <= count_r + CNT_ONE;
      else if (pop && !push)
        count_r <= count_r - CNT_ONE;
    end
  end

  // Output stage.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      out_valid_r <= 1'b0;
      out_data_r <= '0;
    end
    else if (pop)
    begin
      out_valid_r <= 1'b1;
      out_data_r <= mem[rd_ptr_r];
    end
    else if (out_ready)
    begin
      out_valid_r <= 1'b0;
    end
  end

endmodule : ptr_fifo
`default_nettype wire

// File: bench/ptr_sink_model.sv
// Frame multiplexer stand-in that drains pointer words, stalling at will.
`timescale 1ns/1ps
`default_nettype none

module ptr_sink_model
  import ptr_gen_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Stall order from the bench
  input wire logic hold,
  // Pointer stream
  input wire logic ptr_valid,
  output logic ptr_ready,
  input wire ptr_word_t ptr_word,
  // Accepted words
  output logic got,
  output ptr_word_t got_word
);
  // Ready moves after the falling edge and drops at random to stall the stream.
  initial ptr_ready = 1'b0;
  always @(negedge clk)
  begin
    ptr_ready <= resetn && !hold && ($urandom % 4 != 0);
  end

  // A word is taken at a rising edge that sees valid and ready high.
  initial got = 1'b0;
  always @(posedge clk)
  begin
    got <= ptr_valid && ptr_ready && resetn;
    got_word <= ptr_word;
  end
endmodule : ptr_sink_model
`default_nettype wire

// File: bench/tb_top.sv
// Self-checking bench for the pointer generator with its stream sink.
`timescale 1ns/1ps
`default_nettype none

module tb_top
  import ptr_gen_pkg::*;
;
  logic clk = 0, resetn = 0, frame_slot = 0, ssf = 0, ovf = 0, udf = 0, hold = 0;
  logic pi_ctl = 0, rxp = 0, rx_ndf = 0, rx_new = 0, ptr_valid, ptr_ready, got;
  logic fill_low, fill_high, offset_jump, offset_steady, slot_overrun;
  logic [7:0] fill = 8'h80, thr_lo = 8'h28, thr_hi = 8'hc8;
  logic [9:0] rx_ofs = 10'h000, active_offset, m_ofs, m_new;
  logic m_pend;
  ptr_type_t ptype = TYP_AU4;
  gen_state_t gen_state, m_st;
  ptr_word_t ptr_word, got_word, expq[$];
  int n_errors = 0, checked = 0, n_ovr = 0, i, k;
  logic [7:0] corner[4] = '{8'h28, 8'h27, 8'hc8, 8'hc9};

  // The clock toggles every 10 ns, a period of 20 ns.
  always #10 clk = ~clk;

  sdh_pointer_generator dut (.clk(clk), .resetn(resetn), .frame_slot(frame_slot),
    .ptr_type(ptype), .server_signal_fail(ssf), .fill_level(fill), .thr_low(thr_lo),
    .thr_high(thr_hi), .es_overflow(ovf), .es_underflow(udf), .pi_controls(pi_ctl),
    .rx_point(rxp), .rx_ndf_enable(rx_ndf), .rx_new_point(rx_new), .rx_offset(rx_ofs),
    .ptr_valid(ptr_valid), .ptr_ready(ptr_ready), .ptr_word(ptr_word),
    .active_offset(active_offset), .gen_state(gen_state), .fill_low(fill_low),
    .fill_high(fill_high), .offset_jump(offset_jump), .offset_steady(offset_steady),
    .slot_overrun(slot_overrun));

  ptr_sink_model u_sink (.clk(clk), .resetn(resetn), .hold(hold), .ptr_valid(ptr_valid),
    .ptr_ready(ptr_ready), .ptr_word(ptr_word), .got(got), .got_word(got_word));

  // ----------------------------------------------------------------
  // Checking and closing
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic finish_test;
    if (n_errors == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : finish_test

  // Every accepted word is compared with the oldest expected one, in order.
  always @(posedge clk)
  begin
    if (slot_overrun === 1'b1)
      n_ovr++;
    if (got)
    begin
      if (expq.size() == 0)
        check(32'h1, 32'h0);
      else
        check(got_word, expq.pop_front());
    end
  end

  // Outputs must show their idle values while reset is held.
  task automatic reset_check;
    check(ptr_valid, 0);
    check(ptr_word, 0);
    check(gen_state, ST_NORM);
    check(active_offset, OFS_RESET);
    check({offset_jump, offset_steady, slot_overrun}, 3'h2);
    m_ofs = OFS_RESET;
    m_new = OFS_RESET;
    m_pend = 1'b0;
    m_st = ST_NORM;
  endtask : reset_check

  // ----------------------------------------------------------------
  // Stimulus
  // ----------------------------------------------------------------
  // Works out the word for one slot, then pulses the slot request.
  task automatic slot(input logic push);
    ptr_word_t w;
    w = '0;
    w.ssf = ssf;
    w.ss = (ptype == TYP_TU2) ? SS_TU2 : SS_MAIN;
    w.ndf = NDF_OFF;
    w.value = m_ofs;
    if (m_st != ST_NORM)
      m_st = ST_NORM;
    else if (m_pend)
    begin
      w.ndf = NDF_ON;
      w.value = m_new;
      m_ofs = m_new;
      m_pend = 1'b0;
      m_st = ST_NDF;
    end
    else if (fill < thr_lo || fill > thr_hi)
    begin
      w.just = (fill < thr_lo) ? JUST_POS : JUST_NEG;
      w.nbytes = (ptype == TYP_AU4) ? JUST_BYTES_AU4 : JUST_BYTES_ONE;
      w.value = m_ofs ^ ((fill < thr_lo) ? I_MASK : D_MASK);
      m_ofs = (fill < thr_lo) ? m_ofs + OFS_ONE : m_ofs - OFS_ONE;
      m_st = (fill < thr_lo) ? ST_INC : ST_DEC;
    end
    if (push)
      expq.push_back(w);
    frame_slot = 1'b1;
    @(negedge clk);
    frame_slot = 1'b0;
    @(negedge clk);
  endtask : slot

  // One received pointer, qualified by its flags and offset.
  task automatic pt(input logic ndf, input logic nw, input logic [9:0] ofs);
    {rxp, rx_ndf, rx_new, rx_ofs} = {1'b1, ndf, nw, ofs};
    @(negedge clk);
    rxp = 1'b0;
    @(negedge clk);
  endtask : pt

  // Raises one kind of offset event: 1 flag, 2 new-pointer run, 3/4 store slip,
  // 5 store slip while the interpreter does not control writing.
  task automatic ev(input int kind);
    logic [9:0] a;
    a = 10'($urandom);
    pi_ctl = (kind != 5);
    if (kind == 1)
      pt(1'b1, 1'b0, a);
    if (kind == 2)
    begin
      pt(1'b0, 1'b1, a);
      pt(1'b0, 1'b1, a);
      pt(1'b0, 1'b0, a);
      check(offset_jump, m_pend);
      pt(1'b0, 1'b1, ~a);
      pt(1'b0, 1'b1, ~a);
      pt(1'b0, 1'b1, ~a);
      a = ~a;
    end
    if (kind >= 3 && kind <= 5)
    begin
      {ovf, udf} = (kind == 4) ? 2'h1 : 2'h2;
      @(negedge clk);
      {ovf, udf} = 2'h0;
      @(negedge clk);
    end
    if (kind == 1 || kind == 2)
      m_new = a;
    m_pend = m_pend | (kind >= 1 && kind <= 4);
    check(offset_jump, m_pend);
    check(offset_steady, !m_pend);
  endtask : ev

  // Waits, bounded, until every expected word has come out.
  task automatic drain;
    int n;
    n = 0;
    while (expq.size() != 0 && n < 3000)
    begin
      @(negedge clk);
      n++;
    end
    if (expq.size() != 0)
    begin
      n_errors++;
      finish_test();
    end
  endtask : drain

  initial
  begin
    void'($urandom(32'h58e1));
    repeat (6) @(negedge clk);
    reset_check();
    resetn = 1'b1;
    // Random frames over all types, with threshold corners first.
    for (i = 0; i < 80; i++)
    begin
      ptype = ptr_type_t'(2'(i % 4));
      ssf = ($urandom % 8 == 0);
      k = (i == 0) ? 1 : int'($urandom % 8);
      ev(k);
      fill = (i < 16) ? corner[i % 4] : 8'($urandom);
      repeat (3) @(negedge clk);
      check(fill_low, fill < thr_lo);
      check(fill_high, fill > thr_hi);
      slot(1'b1);
      drain();
      check(gen_state, m_st);
      check(active_offset, m_ofs);
      check(offset_jump, m_pend);
    end
    // Corner: a pending jump beats a low fill; the increment comes two slots later.
    fill = 8'h80;
    for (i = 0; i < 3; i++)
      slot(1'b1);
    ev(1);
    fill = 8'h27;
    repeat (3) @(negedge clk);
    for (i = 0; i < 3; i++)
      slot(1'b1);
    drain();
    check(gen_state, m_st);
    check(active_offset, m_ofs);
    // Stalled sink: the buffer fills, one slot is held, a further one merges.
    fill = 8'h80;
    slot(1'b1);
    drain();
    hold = 1'b1;
    n_ovr = 0;
    for (i = 0; i < 18; i++)
      slot(1'b1);
    slot(1'b0);
    repeat (4) @(negedge clk);
    check(n_ovr, 1);
    hold = 1'b0;
    drain();
    repeat (8) @(negedge clk);
    check(ptr_valid, 0);
    // A second reset in mid-run.
    resetn = 1'b0;
    @(negedge clk);
    reset_check();
    // Release again; the first slot after it acts on a low fill at once.
    resetn = 1'b1;
    fill = 8'h27;
    slot(1'b1);
    drain();
    check(gen_state, m_st);
    check(active_offset, m_ofs);
    finish_test();
  end
endmodule : tb_top
`default_nettype wire
